// ==== hdl/upis_core.sv ====
// USB power control, interrupt flags, error flags and status FIFO with APB slave
`timescale 1ns/1ns
module upis_core #(
  parameter int IDLE_CYCLES = upis_pkg::IDLE_3MS_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] line_pins,
  input wire upis_pkg::upis_event_type events,
  output logic module_interrupt_out,
  output logic sleep_block,
  output logic usb_clk_gate_en,
  output logic xcvr_low_power,
  output logic usb_outputs_enable,
  output logic pins_owned,
  output logic analog_enable,
  output logic host_role_enable
);
  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] sync3;
    logic [5:0] line;
    logic sleep_entry_guard;
    logic suspend_request;
    logic module_power_enable;
    logic host_role;
    logic [3:0] ready_cnt;
    logic [7:0] int_flags;
    logic [7:0] int_enables;
    logic [7:0] err_flags;
    logic [7:0] err_enables;
    logic [upis_pkg::FIFO_DEPTH-1:0][5:0] fifo;
    logic [1:0] rd_ptr;
    logic [1:0] wr_ptr;
    logic [2:0] count;
    logic [8:0] k_cnt;
    logic [8:0] quiet_cnt;
    logic [8:0] ta_cnt;
    logic ta_armed;
    logic [19:0] idle_cnt;
    logic [31:0] rdata;
  } upis_state_type;

  upis_state_type s_q, s_d;
  upis_pkg::upis_line_type ln;
  logic wr_acc, rd_acc;
  logic [7:0] w8, ir_set, er_set;
  logic module_busy, activity_pending;

  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set,
                                     input logic [7:0] clr);
    w1c = set | (cur & ~clr);
  endfunction

  assign ln = s_q.line;
  assign wr_acc = psel & penable & pwrite;
  // Read word is registered in the setup cycle so it stands at the access edge
  assign rd_acc = psel & ~penable & ~pwrite;
  assign w8 = pwdata[7:0];
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = s_q.rdata;
  // Busy while powered, or while the power-down settle count runs
  assign module_busy = s_q.module_power_enable | (s_q.ready_cnt != 4'h0);
  // Line activity while the interrupt output is low counts as pending activity
  assign activity_pending = ln.activity & ~module_interrupt_out;
  assign sleep_block = s_q.sleep_entry_guard
                       & (ln.activity | module_interrupt_out);
  assign usb_clk_gate_en = s_q.module_power_enable & ~s_q.suspend_request;
  assign xcvr_low_power = s_q.suspend_request | ~s_q.module_power_enable;
  assign usb_outputs_enable = s_q.module_power_enable;
  assign pins_owned = s_q.module_power_enable;
  assign analog_enable = s_q.module_power_enable;
  assign host_role_enable = s_q.host_role;
  // Interrupt gathers every enabled flag; error path also needs bit 1 enable
  assign module_interrupt_out = |(s_q.int_flags & s_q.int_enables);

  always_comb begin
    logic pwr_on;
    logic host;
    logic [7:0] err_clr;
    pwr_on = s_q.module_power_enable;
    host = s_q.host_role;
    ir_set = 8'h00;
    er_set = 8'h00;
    err_clr = 8'h00;
    s_d = s_q;
    // Three-stage capture; the first stage feeds only the second
    s_d.sync1 = line_pins;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    if (s_q.sync2 == s_q.sync3) begin
      s_d.line = s_q.sync3;
    end
    if (s_q.module_power_enable) begin
      s_d.ready_cnt = 4'(upis_pkg::READY_DELAY_CYC);
    end else if (s_q.ready_cnt != 4'h0) begin
      s_d.ready_cnt = s_q.ready_cnt - 4'h1;
    end
    // Resume detection works in suspend too, the line logic is not clock gated here
    s_d.k_cnt = ln.k_state ? s_q.k_cnt + 9'h001 : 9'h000;
    if (s_q.k_cnt == 9'(upis_pkg::K_STATE_CYC - 1) && ln.k_state) begin
      ir_set[upis_pkg::IR_RESUME_BIT] = pwr_on;
    end
    s_d.quiet_cnt = ln.activity ? 9'h000 : s_q.quiet_cnt + 9'h001;
    if (s_q.quiet_cnt == 9'(upis_pkg::IDLE_ACT_CYC - 1) && !ln.activity) begin
      ir_set[upis_pkg::IR_ATTACH_BIT] = pwr_on & host & ~ln.se0;
    end
    if (s_q.quiet_cnt == 9'(upis_pkg::IDLE_ACT_CYC)) begin
      s_d.quiet_cnt = s_q.quiet_cnt;
    end
    s_d.idle_cnt = (ln.j_state && !ln.activity) ? s_q.idle_cnt + 20'h00001 : 20'h00000;
    if (s_q.idle_cnt == 20'(IDLE_CYCLES - 1) && ln.j_state && !ln.activity) begin
      ir_set[upis_pkg::IR_IDLE_BIT] = pwr_on;
    end
    if (s_q.idle_cnt == 20'(IDLE_CYCLES)) begin
      s_d.idle_cnt = s_q.idle_cnt;
    end
    // Turnaround timer starts at end of packet and stops on fresh activity
    if (ln.eop) begin
      s_d.ta_armed = 1'b1;
      s_d.ta_cnt = 9'h000;
    end else if (ln.activity) begin
      s_d.ta_armed = 1'b0;
    end else if (s_q.ta_armed) begin
      s_d.ta_cnt = s_q.ta_cnt + 9'h001;
      if (s_q.ta_cnt == 9'(upis_pkg::TURNAROUND_CYC)) begin
        s_d.ta_armed = 1'b0;
        er_set[upis_pkg::ER_TURNAROUND_BIT] = pwr_on & host;
      end
    end
    if (pwr_on) begin
      ir_set[upis_pkg::IR_STALL_BIT] = events.stall_hs;
      ir_set[upis_pkg::IR_SOF_BIT] = host ? events.sof_threshold : events.sof_rx;
      ir_set[upis_pkg::IR_RST_DET_BIT] = host ? events.detach : events.bus_reset;
      er_set[upis_pkg::ER_BITSTUFF_BIT] |= events.bitstuff_err;
      er_set[upis_pkg::ER_PID_BIT] |= events.pid_err;
      er_set[upis_pkg::ER_DATASIZE_BIT] |= events.datasize_err;
      er_set[upis_pkg::ER_BUSMATRIX_BIT] |= events.busmatrix_err;
      er_set[upis_pkg::ER_DMA_BIT] |= events.dma_err;
      er_set[upis_pkg::ER_CRC16_BIT] |= events.crc16_err;
      er_set[upis_pkg::ER_CRC5_EOF_BIT] |= host
        ? (events.sof_count_zero & ln.busy_xfer)
        : events.crc5_err;
    end
    // Status entries push; a full FIFO drops the newest entry
    if (pwr_on && events.token_done && s_q.count != 3'(upis_pkg::FIFO_DEPTH)) begin
      s_d.fifo[s_q.wr_ptr] = events.token_status;
      s_d.wr_ptr = s_q.wr_ptr + 2'h1;
      s_d.count = s_d.count + 3'h1;
    end
    // Done flag stays up while any entry waits
    ir_set[upis_pkg::IR_TRN_BIT] = (s_q.count != 3'h0);
    if (wr_acc) begin
      unique case (paddr)
        upis_pkg::OFF_POWER_CONTROL: begin
          s_d.sleep_entry_guard = w8[upis_pkg::PWR_SLEEP_GUARD_BIT];
          s_d.suspend_request = w8[upis_pkg::PWR_SUSPEND_BIT];
          s_d.module_power_enable = w8[upis_pkg::PWR_ENABLE_BIT];
        end
        upis_pkg::OFF_INT_FLAGS: begin
          if (w8[upis_pkg::IR_TRN_BIT] && s_q.count != 3'h0) begin
            s_d.rd_ptr = s_q.rd_ptr + 2'h1;
            s_d.count = s_d.count - 3'h1;
            ir_set[upis_pkg::IR_TRN_BIT] = (s_d.count != 3'h0);
          end
          s_d.int_flags = w1c(s_q.int_flags, 8'h00, w8);
        end
        upis_pkg::OFF_INT_ENABLES: s_d.int_enables = w8;
        upis_pkg::OFF_ERR_FLAGS: err_clr = w8;
        upis_pkg::OFF_ERR_ENABLES: s_d.err_enables = w8;
        upis_pkg::OFF_HOST_CONTROL: s_d.host_role = w8[upis_pkg::HC_HOST_ROLE_BIT];
        default: ;
      endcase
    end
    s_d.err_flags = w1c(s_q.err_flags, er_set, err_clr);
    // Only enabled errors raise the aggregate; it clears when none remain
    ir_set[upis_pkg::IR_ERR_BIT] = |(s_d.err_flags & s_q.err_enables);
    s_d.int_flags[upis_pkg::IR_ERR_BIT] = 1'b0;
    s_d.int_flags = (wr_acc && paddr == upis_pkg::OFF_INT_FLAGS)
                    ? s_d.int_flags | ir_set
                    : w1c(s_q.int_flags, ir_set, 8'h00) & ~8'h02 | ir_set;
    s_d.rdata = 32'h0000_0000;
    if (rd_acc) begin
      unique case (paddr)
        upis_pkg::OFF_POWER_CONTROL: begin
          s_d.rdata[upis_pkg::PWR_ACT_PEND_BIT] = activity_pending;
          s_d.rdata[upis_pkg::PWR_SLEEP_GUARD_BIT] = s_q.sleep_entry_guard;
          s_d.rdata[upis_pkg::PWR_BUSY_BIT] = module_busy;
          s_d.rdata[upis_pkg::PWR_SUSPEND_BIT] = s_q.suspend_request;
          s_d.rdata[upis_pkg::PWR_ENABLE_BIT] = s_q.module_power_enable;
        end
        upis_pkg::OFF_INT_FLAGS: s_d.rdata[7:0] = s_q.int_flags;
        upis_pkg::OFF_INT_ENABLES: s_d.rdata[7:0] = s_q.int_enables;
        upis_pkg::OFF_ERR_FLAGS: s_d.rdata[7:0] = s_q.err_flags;
        upis_pkg::OFF_ERR_ENABLES: s_d.rdata[7:0] = s_q.err_enables;
        upis_pkg::OFF_TRANS_STATUS: begin
          if (s_q.count != 3'h0) begin
            s_d.rdata[7:2] = s_q.fifo[s_q.rd_ptr];
          end
        end
        upis_pkg::OFF_HOST_CONTROL: s_d.rdata[upis_pkg::HC_HOST_ROLE_BIT] = s_q.host_role;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // upis_core

// ==== hdl/upis_pkg.sv ====
// Package for the USB power and interrupt status block: register map, fields, timings
package upis_pkg;
  localparam logic [7:0] OFF_POWER_CONTROL = 8'h00;
  localparam logic [7:0] OFF_INT_FLAGS = 8'h04;
  localparam logic [7:0] OFF_INT_ENABLES = 8'h08;
  localparam logic [7:0] OFF_ERR_FLAGS = 8'h0C;
  localparam logic [7:0] OFF_ERR_ENABLES = 8'h10;
  localparam logic [7:0] OFF_TRANS_STATUS = 8'h14;
  localparam logic [7:0] OFF_HOST_CONTROL = 8'h18;
  localparam int PWR_ACT_PEND_BIT = 7;
  localparam int PWR_SLEEP_GUARD_BIT = 4;
  localparam int PWR_BUSY_BIT = 3;
  localparam int PWR_SUSPEND_BIT = 1;
  localparam int PWR_ENABLE_BIT = 0;
  localparam int IR_STALL_BIT = 7;
  localparam int IR_ATTACH_BIT = 6;
  localparam int IR_RESUME_BIT = 5;
  localparam int IR_IDLE_BIT = 4;
  localparam int IR_TRN_BIT = 3;
  localparam int IR_SOF_BIT = 2;
  localparam int IR_ERR_BIT = 1;
  localparam int IR_RST_DET_BIT = 0;
  localparam int ER_BITSTUFF_BIT = 7;
  localparam int ER_BUSMATRIX_BIT = 6;
  localparam int ER_DMA_BIT = 5;
  localparam int ER_TURNAROUND_BIT = 4;
  localparam int ER_DATASIZE_BIT = 3;
  localparam int ER_CRC16_BIT = 2;
  localparam int ER_CRC5_EOF_BIT = 1;
  localparam int ER_PID_BIT = 0;
  localparam int HC_HOST_ROLE_BIT = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CLK_MHZ = 125;
  localparam int K_STATE_NS = 2500;
  localparam int IDLE_ACT_NS = 2500;
  localparam int IDLE_3MS_US = 3000;
  localparam int K_STATE_CYC = (K_STATE_NS * CLK_MHZ + 999) / 1000;
  localparam int IDLE_ACT_CYC = (IDLE_ACT_NS * CLK_MHZ + 999) / 1000;
  localparam int IDLE_3MS_CYC = IDLE_3MS_US * CLK_MHZ;
  localparam int FULL_BIT_NS_X10 = 833;
  localparam int TURNAROUND_BITS = 16;
  localparam int TURNAROUND_CYC = (TURNAROUND_BITS * FULL_BIT_NS_X10 * CLK_MHZ) / 10000;
  localparam int READY_DELAY_CYC = 8;
  localparam int FIFO_DEPTH = 4;

  typedef struct packed {
    logic se0;
    logic j_state;
    logic k_state;
    logic activity;
    logic eop;
    logic busy_xfer;
  } upis_line_type;

  typedef struct packed {
    logic stall_hs;
    logic bus_reset;
    logic detach;
    logic token_done;
    logic [5:0] token_status;
    logic sof_rx;
    logic sof_threshold;
    logic sof_count_zero;
    logic bitstuff_err;
    logic pid_err;
    logic datasize_err;
    logic crc16_err;
    logic crc5_err;
    logic busmatrix_err;
    logic dma_err;
  } upis_event_type;
endpackage

// ==== bench/upis_chk_sva.sv ====
// Port checks for the power and interrupt status block
`timescale 1ns/1ns
module upis_chk #(
  parameter int IDLE_CYCLES = 50
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic module_interrupt_out,
  input wire logic sleep_block,
  input wire logic usb_clk_gate_en,
  input wire logic xcvr_low_power,
  input wire logic usb_outputs_enable,
  input wire logic pins_owned,
  input wire logic analog_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic acc;
  logic pw;
  assign acc = psel && penable;
  assign pw = acc && pwrite && paddr == upis_pkg::OFF_POWER_CONTROL;
  chk_zero_wait: assert property (psel |-> pready && !pslverr)
    else $error("slave stalled or flagged an error");
  chk_read_idle: assert property (!(psel && !penable && !pwrite) |=> prdata == 32'h0)
    else $error("read data without a read");
  chk_power_on: assert property (pw && pwdata[0] |=> usb_outputs_enable && analog_enable)
    else $error("power enable did not turn the module on");
  chk_power_off: assert property (pw && !pwdata[0] |=> !pins_owned && xcvr_low_power)
    else $error("pins still owned with power off");
  chk_suspend_gate: assert property (pw && pwdata[1:0] == 2'b11 |=> !usb_clk_gate_en)
    else $error("suspend left the clock running");
  chk_gate_pair: assert property (usb_clk_gate_en |-> analog_enable && !xcvr_low_power)
    else $error("clock runs while transceiver is low power");
  chk_pins_follow: assert property (usb_outputs_enable == pins_owned && pins_owned == analog_enable)
    else $error("power outputs disagree");
  chk_guard_off: assert property (pw && !pwdata[4] |=> !sleep_block)
    else $error("sleep blocked with guard clear");
  chk_mask_all: assert property (acc && pwrite && paddr == upis_pkg::OFF_INT_ENABLES
    && pwdata[7:0] == 8'h00 |=> !module_interrupt_out)
    else $error("interrupt with all enables clear");
  cov_read: cover property (acc && !pwrite);
  cov_irq: cover property ($rose(module_interrupt_out));
  cov_sleep: cover property (sleep_block);
endmodule // upis_chk

// ==== bench/upis_bus_model.sv ====
// Behavioural cable partner: line state and event pulses
`timescale 1ns/1ns
module upis_bus_model (
  input wire logic clk,
  input wire upis_pkg::upis_event_type ev_req,
  input wire logic [9:0] k_len,
  output logic [5:0] line_pins,
  output upis_pkg::upis_event_type events
);
  logic [9:0] k_cnt_q;
  initial k_cnt_q = 10'h000;
  initial events = '0;
  always @(posedge clk) begin
    events <= ev_req;
    if (k_len != 10'h000) k_cnt_q <= k_len;
    else if (k_cnt_q != 10'h000) k_cnt_q <= k_cnt_q - 10'h001;
  end
  // Idle shows J; a wake-up holds K with activity for k_len cycles
  assign line_pins = (k_cnt_q != 10'h000) ? 6'h0C : 6'h10;
endmodule // upis_bus_model

// ==== bench/test_usb_power_and_interrupt_status.sv ====
// Self-checking bench for the power and interrupt status block
`timescale 1ns/1ns
module test_usb_power_and_interrupt_status;
  localparam int IDLE_CYCLES = 4000;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed, r;
  logic [5:0] line_pins;
  logic [9:0] k_len;
  logic module_interrupt_out, sleep_block, usb_clk_gate_en, xcvr_low_power;
  logic usb_outputs_enable, pins_owned, analog_enable, host_role_enable;
  upis_pkg::upis_event_type events, ev_req, e;
  logic [7:0] exp_q[$];
  int fail_count, checks_done;
  upis_core #(.IDLE_CYCLES(IDLE_CYCLES)) i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_pins(line_pins), .events(events),
    .module_interrupt_out(module_interrupt_out), .sleep_block(sleep_block),
    .usb_clk_gate_en(usb_clk_gate_en), .xcvr_low_power(xcvr_low_power),
    .usb_outputs_enable(usb_outputs_enable), .pins_owned(pins_owned),
    .analog_enable(analog_enable), .host_role_enable(host_role_enable));
  upis_bus_model i_cable (.clk(clk), .ev_req(ev_req), .k_len(k_len), .line_pins(line_pins),
    .events(events));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s", $time, what);
    end
  endtask
  // Read data stands through the access cycle and is taken at the pready edge
  always @(posedge clk) begin
    if (!sys_rst && psel && penable && !pwrite && pready === 1'b1) begin
      chk(exp_q.size() > 0 && prdata === {24'h0, exp_q.pop_front()}, "read data");
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk(1'b0, "no ready");
      tally_and_finish();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    apb(1'b0, a, 8'h00);
  endtask
  task automatic ev(input upis_pkg::upis_event_type p);
    ev_req <= p;
    @(posedge clk);
    ev_req <= '0;
    @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata, k_len} = '0;
    sys_rst = 1'b1;
    ev_req = '0;
    fail_count = 0;
    checks_done = 0;
    seed = 32'h5E05A852;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 32; a += 4) rd(8'(a), 8'h00);
    chk(xcvr_low_power === 1'b1 && usb_outputs_enable === 1'b0, "reset outputs");
    wr(upis_pkg::OFF_POWER_CONTROL, 8'h11);
    rd(upis_pkg::OFF_POWER_CONTROL, 8'h19);
    chk(usb_clk_gate_en === 1'b1 && xcvr_low_power === 1'b0, "power on");
    e = '0;
    e.stall_hs = 1'b1;
    e.sof_rx = 1'b1;
    e.bus_reset = 1'b1;
    ev(e);
    rd(upis_pkg::OFF_INT_FLAGS, 8'h85);
    chk(module_interrupt_out === 1'b0 && sleep_block === 1'b0, "masked");
    seed = lfsr(seed);
    r = (seed & 32'hDF) | 32'h01; // Resume stays masked while awake
    wr(upis_pkg::OFF_INT_ENABLES, r[7:0]);
    rd(upis_pkg::OFF_INT_ENABLES, r[7:0]);
    chk(module_interrupt_out === |(r[7:0] & 8'h85), "irq or");
    chk(sleep_block === 1'b1, "guard");
    wr(upis_pkg::OFF_INT_FLAGS, 8'h00);
    rd(upis_pkg::OFF_INT_FLAGS, 8'h85);
    wr(upis_pkg::OFF_INT_FLAGS, 8'h85);
    rd(upis_pkg::OFF_INT_FLAGS, 8'h00);
    chk(module_interrupt_out === 1'b0, "cleared");
    wr(upis_pkg::OFF_ERR_ENABLES, 8'h04);
    e = '0;
    e.bitstuff_err = 1'b1;
    e.pid_err = 1'b1;
    e.datasize_err = 1'b1;
    ev(e);
    rd(upis_pkg::OFF_ERR_FLAGS, 8'h89);
    rd(upis_pkg::OFF_INT_FLAGS, 8'h00);
    e = '0;
    e.crc16_err = 1'b1;
    e.busmatrix_err = 1'b1;
    e.dma_err = 1'b1;
    ev(e);
    rd(upis_pkg::OFF_ERR_FLAGS, 8'hED);
    rd(upis_pkg::OFF_INT_FLAGS, 8'h02);
    chk(module_interrupt_out === r[1], "error path");
    wr(upis_pkg::OFF_ERR_FLAGS, 8'hFF);
    rd(upis_pkg::OFF_INT_FLAGS, 8'h00);
    e = '0;
    e.token_done = 1'b1;
    e.token_status = 6'h2A;
    ev(e);
    e.token_status = 6'h15;
    ev(e);
    rd(upis_pkg::OFF_INT_FLAGS, 8'h08);
    rd(upis_pkg::OFF_TRANS_STATUS, 8'hA8);
    wr(upis_pkg::OFF_INT_FLAGS, 8'h08);
    rd(upis_pkg::OFF_TRANS_STATUS, 8'h54);
    rd(upis_pkg::OFF_INT_FLAGS, 8'h08);
    wr(upis_pkg::OFF_INT_FLAGS, 8'h08);
    rd(upis_pkg::OFF_INT_FLAGS, 8'h00);
    wr(upis_pkg::OFF_POWER_CONTROL, 8'h03);
    chk(usb_clk_gate_en === 1'b0 && xcvr_low_power === 1'b1, "suspend");
    wr(upis_pkg::OFF_INT_ENABLES, 8'h20);
    k_len <= 10'd330;
    @(posedge clk);
    k_len <= 10'd0;
    repeat (8) @(posedge clk);
    rd(upis_pkg::OFF_POWER_CONTROL, 8'h8B);
    repeat (upis_pkg::K_STATE_CYC + 13) @(posedge clk);
    rd(upis_pkg::OFF_INT_FLAGS, 8'h20);
    chk(module_interrupt_out === 1'b1, "resume irq");
    wr(upis_pkg::OFF_INT_ENABLES, 8'h00);
    wr(upis_pkg::OFF_INT_FLAGS, 8'h20);
    repeat (IDLE_CYCLES + 8) @(posedge clk);
    rd(upis_pkg::OFF_INT_FLAGS, 8'h10);
    wr(upis_pkg::OFF_HOST_CONTROL, 8'h01);
    rd(upis_pkg::OFF_HOST_CONTROL, 8'h01);
    e = '0;
    e.detach = 1'b1;
    e.sof_threshold = 1'b1;
    e.sof_rx = 1'b1;
    e.crc5_err = 1'b1;
    ev(e);
    rd(upis_pkg::OFF_INT_FLAGS, 8'h15);
    rd(upis_pkg::OFF_ERR_FLAGS, 8'h00);
    wr(upis_pkg::OFF_POWER_CONTROL, 8'h00);
    rd(upis_pkg::OFF_POWER_CONTROL, 8'h08);
    chk(pins_owned === 1'b0 && xcvr_low_power === 1'b1, "power off");
    repeat (upis_pkg::READY_DELAY_CYC + 4) @(posedge clk); // Nothing else touched
    rd(upis_pkg::OFF_POWER_CONTROL, 8'h00);
    repeat (2) @(posedge clk);
    chk(exp_q.size() == 0, "reads left unanswered");
    tally_and_finish();
  end
endmodule // test_usb_power_and_interrupt_status
bind upis_core upis_chk #(.IDLE_CYCLES(IDLE_CYCLES)) i_chk (.clk(clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .module_interrupt_out(module_interrupt_out), .sleep_block(sleep_block),
  .usb_clk_gate_en(usb_clk_gate_en), .xcvr_low_power(xcvr_low_power),
  .usb_outputs_enable(usb_outputs_enable), .pins_owned(pins_owned),
  .analog_enable(analog_enable));
